/* hw/wsr_top.sv */
// Behaviour
// - Channel 1 waits its switch-on delay of 0-999 tenths; zero means none.
// - Channel 2 has its own independent switch-on delay, default zero.
// - Each channel compares net, gross or peak; gross after reset.
// - Peak source uses last captured peak, even with peak tracking off.
// - Contact polarity per channel: normally open default, closed inverts.
// - Sign setting restricts operation to positive or negative weight.
// - Stable-only mode gates the output with the stability flag.
// - Channel 2 hysteresis band 0-999, default 2, below threshold.
// - Channel 2 max-on time forces output off; zero disables it.
// - Input test mode shows live inputs, input 1 leftmost, functions off.
// - Output test mode drives outputs from operator digits.
// - In output test mode the LEDs mirror the forced outputs.
// - Demand mode: input 2 requests a report if stable, moved 20 div.
// - Channel 1 has the same source, polarity, sign, stability options.
// - Channel 1 hysteresis band 0-999, default 2.
// - Channel 1 max-on time forces output off; zero disables it.
module wsr_top
  import wsr_pkg::*;
#(
  parameter int TICK_CYCLES = WSR_TICK_CYC
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     nrst,
  // Avalon-MM register slave
  input  wire logic [3:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output      logic [31:0]              avs_readdata,
  output      logic                     avs_waitrequest,
  // Weighing front end
  input  wire logic signed [WSR_WW-1:0] net_weight,
  input  wire logic signed [WSR_WW-1:0] gross_weight,
  input  wire logic signed [WSR_WW-1:0] peak_weight,
  input  wire logic                     weight_stable,
  // Logic input pins, bit 0 is input 1
  input  wire logic [1:0]               logic_in,
  // Relays, LEDs, report request
  output      logic [1:0]               relay_out,
  output      logic [1:0]               led_out,
  output      logic                     report_req
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic                     rst_meta_r;
  logic                     rst_n;
  logic [1:0]               in_meta_r;
  logic [1:0]               in_sync_r;
  logic                     in2_d_r;
  logic [22:0]              tick_cnt_r;
  logic                     tick_r;

  logic signed [WSR_WW-1:0] thr_r [2];
  logic [4:0]               cfg_r [2];
  logic [9:0]               hys_r [2];
  logic [9:0]               dly_r [2];
  logic [9:0]               max_r [2];
  logic                     input_test_mode_r;
  logic                     output_test_mode_r;
  logic [1:0]               out_digit_r;
  logic                     demand_mode_r;

  logic                     waitreq_r;
  logic [31:0]              rdata_r;
  logic [31:0]              rdata_nxt;
  logic [1:0]               relay_r;
  logic [1:0]               relay_nxt;
  logic [1:0]               led_r;
  logic [1:0]               led_nxt;
  logic                     report_r;
  logic signed [WSR_WW-1:0] last_rep_r;
  logic                     have_rep_r;

  logic [1:0]               act;
  wsr_state_e               st [2];
  logic                     wr_en;
  logic                     rd_take;
  logic                     wr_ch;
  logic [2:0]               wr_fld;
  logic                     shared_sel;
  logic                     in2_rise;
  logic signed [WSR_WW:0]   rep_diff;
  logic signed [WSR_WW:0]   rep_abs;
  logic                     rep_moved;
  logic                     rep_ok;
  logic [8:0]               status;

  ////////////////////////////////////////////////////////////////////
  // Range clamp shared by all 0..999 settings
  function automatic logic [9:0] clamp999(input logic [31:0] d);
    clamp999 = (d > {22'h000000, WSR_TMAX}) ? WSR_TMAX : d[9:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Pins are asynchronous; only the second stage feeds logic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_r <= 2'h0;
      in_sync_r <= 2'h0;
      in2_d_r   <= 1'b0;
    end else begin
      in_meta_r <= logic_in;
      in_sync_r <= in_meta_r;
      in2_d_r   <= in_sync_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Tenth-second tick; timers may start mid-tick, so one tick of slack
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 23'h000000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 23'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 23'h000000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 23'h000001;
      tick_r     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus decode: one wait cycle, then a single-cycle acknowledge
  assign wr_en      = avs_write && !waitreq_r;
  assign rd_take    = avs_read && waitreq_r;
  assign wr_ch      = avs_address[3];
  assign wr_fld     = avs_address[2:0];
  assign shared_sel = !wr_ch;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_r <= 1'b1;
    end else begin
      waitreq_r <= !((avs_read || avs_write) && waitreq_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Setting registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        thr_r[c] <= '0;
        cfg_r[c] <= WSR_CFG_RST;
        hys_r[c] <= WSR_HYS_RST;
        dly_r[c] <= WSR_DLY_RST;
        max_r[c] <= WSR_MAX_RST;
      end
    end else if (wr_en) begin
      for (int c = 0; c < 2; c++) begin
        if (wr_ch == c[0]) begin
          if (wr_fld == WSR_F_THR) begin
            thr_r[c] <= avs_writedata[WSR_WW-1:0];
          end
          if (wr_fld == WSR_F_CFG) begin
            cfg_r[c] <= avs_writedata[4:0];
          end
          if (wr_fld == WSR_F_HYS) begin
            hys_r[c] <= clamp999(avs_writedata);
          end
          if (wr_fld == WSR_F_DLY) begin
            dly_r[c] <= clamp999(avs_writedata);
          end
          if (wr_fld == WSR_F_MAX) begin
            max_r[c] <= clamp999(avs_writedata);
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      input_test_mode_r  <= 1'b0;
      output_test_mode_r <= 1'b0;
      out_digit_r        <= 2'h0;
      demand_mode_r      <= 1'b0;
    end else if (wr_en && shared_sel) begin
      if (wr_fld == WSR_F_TEST) begin
        input_test_mode_r  <= avs_writedata[0];
        output_test_mode_r <= avs_writedata[1];
        out_digit_r        <= avs_writedata[3:2];
      end
      if (wr_fld == WSR_F_MODE) begin
        demand_mode_r <= avs_writedata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path; unmapped words read zero, writes to them are dropped
  assign status = {st[1], st[0], weight_stable,
                   in_sync_r[0], in_sync_r[1], act};

  always_comb begin
    rdata_nxt = 32'h00000000;
    case (wr_fld)
      WSR_F_THR: rdata_nxt = {{8{thr_r[wr_ch][WSR_WW-1]}}, thr_r[wr_ch]};
      WSR_F_CFG: rdata_nxt = {27'h0000000, cfg_r[wr_ch]};
      WSR_F_HYS: rdata_nxt = {22'h000000, hys_r[wr_ch]};
      WSR_F_DLY: rdata_nxt = {22'h000000, dly_r[wr_ch]};
      WSR_F_MAX: rdata_nxt = {22'h000000, max_r[wr_ch]};
      WSR_F_TEST: begin
        if (shared_sel) begin
          rdata_nxt = {28'h0000000, out_digit_r,
                       output_test_mode_r, input_test_mode_r};
        end
      end
      WSR_F_MODE: begin
        if (shared_sel) begin
          rdata_nxt = {31'h00000000, demand_mode_r};
        end
      end
      WSR_F_STAT: begin
        if (shared_sel) begin
          rdata_nxt = {23'h000000, status};
        end
      end
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (rd_take) begin
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Setpoint channels
  generate
    for (genvar g = 0; g < 2; g++) begin : gen_ch
      wsr_channel u_ch (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .tick   (tick_r),
        .net    (net_weight),
        .gross  (gross_weight),
        .peak   (peak_weight),
        .stable (weight_stable),
        .cfg    (cfg_r[g]),
        .thr    (thr_r[g]),
        .hys    (hys_r[g]),
        .dly    (dly_r[g]),
        .maxon  (max_r[g]),
        .active (act[g]),
        .state  (st[g])
      );

      // Test digits bypass polarity: 1 always means contact on
      assign relay_nxt[g] = output_test_mode_r ? out_digit_r[g]
                          : act[g] ^ cfg_r[g][WSR_CFG_NC];
      assign led_nxt[g]   = output_test_mode_r ? out_digit_r[g]
                          : act[g];
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      relay_r <= 2'h0;
      led_r   <= 2'h0;
    end else begin
      relay_r <= relay_nxt;
      led_r   <= led_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // On-demand report; input test mode suspends the input function
  assign in2_rise  = in_sync_r[1] && !in2_d_r &&
                     !input_test_mode_r && demand_mode_r;
  assign rep_diff  = $signed({gross_weight[WSR_WW-1], gross_weight}) -
                     $signed({last_rep_r[WSR_WW-1], last_rep_r});
  assign rep_abs   = rep_diff[WSR_WW] ? -rep_diff : rep_diff;
  assign rep_moved = !have_rep_r ||
                     (rep_abs >= $signed({1'b0, WSR_REP_DIV}));
  assign rep_ok    = in2_rise && weight_stable && rep_moved;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      report_r   <= 1'b0;
      last_rep_r <= '0;
      have_rep_r <= 1'b0;
    end else begin
      report_r <= rep_ok;
      if (rep_ok) begin
        last_rep_r <= gross_weight;
        have_rep_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = waitreq_r;
  assign relay_out       = relay_r;
  assign led_out         = led_r;
  assign report_req      = report_r;

endmodule // wsr_top

/* pkg/wsr_pkg.sv */
package wsr_pkg;

  ////////////////////////////////////////////////////////////////////
  // Widths and timing
  localparam int          WSR_WW      = 24;
  localparam int          WSR_TW      = 10;
  localparam int          WSR_CLK_HZ  = 40_000_000;
  localparam int          WSR_TICK_MS = 100;
  localparam int          WSR_TICK_CYC = WSR_CLK_HZ / 1000 * WSR_TICK_MS;
  localparam logic [9:0]  WSR_TMAX    = 10'h3E7;
  localparam logic [23:0] WSR_REP_DIV = 24'h000014;

  ////////////////////////////////////////////////////////////////////
  // Register field offsets inside a channel block
  localparam logic [2:0] WSR_F_THR  = 3'h0;
  localparam logic [2:0] WSR_F_CFG  = 3'h1;
  localparam logic [2:0] WSR_F_HYS  = 3'h2;
  localparam logic [2:0] WSR_F_DLY  = 3'h3;
  localparam logic [2:0] WSR_F_MAX  = 3'h4;
  // Shared registers live in block 0 only
  localparam logic [2:0] WSR_F_TEST = 3'h5;
  localparam logic [2:0] WSR_F_MODE = 3'h6;
  localparam logic [2:0] WSR_F_STAT = 3'h7;

  ////////////////////////////////////////////////////////////////////
  // Config bit positions and reset values
  localparam int         WSR_CFG_SRC = 0;
  localparam int         WSR_CFG_NC  = 2;
  localparam int         WSR_CFG_NEG = 3;
  localparam int         WSR_CFG_STB = 4;
  localparam logic [1:0] WSR_SRC_NET   = 2'h0;
  localparam logic [1:0] WSR_SRC_GROSS = 2'h1;
  localparam logic [1:0] WSR_SRC_PEAK  = 2'h2;
  localparam logic [4:0] WSR_CFG_RST = 5'h01;
  localparam logic [9:0] WSR_HYS_RST = 10'h002;
  localparam logic [9:0] WSR_DLY_RST = 10'h000;
  localparam logic [9:0] WSR_MAX_RST = 10'h000;

  typedef enum logic [1:0] {
    WSR_IDLE  = 2'b00,
    WSR_DELAY = 2'b01,
    WSR_ON    = 2'b11,
    WSR_SPENT = 2'b10
  } wsr_state_e;

endpackage

/* hw/wsr_channel.sv */
module wsr_channel
  import wsr_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     tick,
  // Weights from the front end
  input  wire logic signed [WSR_WW-1:0] net,
  input  wire logic signed [WSR_WW-1:0] gross,
  input  wire logic signed [WSR_WW-1:0] peak,
  input  wire logic                     stable,
  // Settings
  input  wire logic        [4:0]        cfg,
  input  wire logic signed [WSR_WW-1:0] thr,
  input  wire logic        [9:0]        hys,
  input  wire logic        [9:0]        dly,
  input  wire logic        [9:0]        maxon,
  // Result
  output      logic                     active,
  output      wsr_state_e               state
);

  wsr_state_e                 state_r;
  wsr_state_e                 state_nxt;
  logic        [9:0]          cnt_r;
  logic        [9:0]          cnt_nxt;
  logic signed [WSR_WW-1:0]   w;
  logic signed [WSR_WW:0]     mag;
  logic signed [WSR_WW:0]     lim;
  logic signed [WSR_WW:0]     rel;
  logic        [1:0]          src;
  logic                       neg;
  logic                       sign_ok;
  logic                       above;
  logic                       below;

  ////////////////////////////////////////////////////////////////////
  // Peak is the latched last peak, tracking on or off
  assign src = cfg[WSR_CFG_SRC+1:WSR_CFG_SRC];
  assign w   = (src == WSR_SRC_NET)  ? net :
               (src == WSR_SRC_PEAK) ? peak : gross;
  assign neg = cfg[WSR_CFG_NEG];
  assign sign_ok = neg ? w[WSR_WW-1] : !w[WSR_WW-1];
  assign mag = neg ? -$signed({w[WSR_WW-1], w})
                   : $signed({w[WSR_WW-1], w});
  assign lim = $signed({thr[WSR_WW-1], thr});
  assign rel = lim - $signed({15'h0000, hys});
  assign above = sign_ok && (mag > lim);
  assign below = !sign_ok || (mag < rel);

  ////////////////////////////////////////////////////////////////////
  // Delay needs unbroken exceedance; max-on counts from exceedance
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WSR_IDLE: begin
        if (above) begin
          state_nxt = (dly == 10'h000) ? WSR_ON : WSR_DELAY;
        end
      end
      WSR_DELAY: begin
        if (!above) begin
          state_nxt = WSR_IDLE;
        end else if (cnt_r >= dly) begin
          state_nxt = WSR_ON;
        end
      end
      WSR_ON: begin
        if (below) begin
          state_nxt = WSR_IDLE;
        end else if (maxon != 10'h000 && cnt_r >= maxon) begin
          state_nxt = WSR_SPENT;
        end
      end
      WSR_SPENT: begin
        if (below) begin
          state_nxt = WSR_IDLE;
        end
      end
      default: state_nxt = WSR_IDLE;
    endcase
  end

  // Saturates so a long-held output cannot wrap back into range
  assign cnt_nxt = (state_r == WSR_IDLE) ? 10'h000 :
                   (tick && cnt_r != WSR_TMAX) ? cnt_r + 10'h001 :
                   cnt_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= WSR_IDLE;
      cnt_r   <= 10'h000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign active = (state_r == WSR_ON) &&
                  (!cfg[WSR_CFG_STB] || stable);
  assign state  = state_r;

endmodule // wsr_channel

/* sim/wsr_assertions.sv */
module wsr_assertions
  import wsr_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // Register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Front end and outputs
  input wire logic        weight_stable,
  input wire logic [1:0]  relay_out,
  input wire logic [1:0]  led_out,
  input wire logic        report_req
);
  ////////////////////////////////////////////////////////////////////
  // Shadow of the settings that decide what the pins must show
  logic [4:0] c1_r;
  logic [3:0] t_r;
  logic       m_r;
  wire        wr_ok = avs_write && !avs_waitrequest;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      c1_r <= 5'h01;
      t_r  <= 4'h0;
      m_r  <= 1'b0;
    end else if (wr_ok) begin
      if (avs_address == 4'h1) c1_r <= avs_writedata[4:0];
      if (avs_address == 4'h5) t_r <= avs_writedata[3:0];
      if (avs_address == 4'h6) m_r <= avs_writedata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Settings settled one edge, so registered outputs have caught up
  sequence s_forced;
    t_r[1] && $stable(t_r);
  endsequence
  sequence s_normal;
    !t_r[1] && !c1_r[4] && $stable(t_r) && $stable(c1_r);
  endsequence

  a_bus_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("bus request not answered after one cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_unmapped_zero: assert property (
    s_req ##0 (avs_read && avs_address > 4'hC) |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_report_pulse: assert property (report_req |=> !report_req)
    else $error("report request longer than one cycle");
  a_report_stable: assert property (
    report_req |-> $past(weight_stable))
    else $error("report accepted on unstable weight");
  a_report_mode: assert property (report_req |-> $past(m_r))
    else $error("report accepted outside demand mode");
  a_report_blocked: assert property (
    t_r[0] && $past(t_r[0]) |-> !report_req)
    else $error("report accepted in input test mode");
  a_led_mirror: assert property (s_forced |-> led_out == relay_out)
    else $error("leds differ from forced outputs");
  a_forced_relay: assert property (
    s_forced |-> relay_out == t_r[3:2])
    else $error("relays differ from test digits");
  a_contact_pol: assert property (
    s_normal |-> relay_out[0] == (led_out[0] ^ c1_r[2]))
    else $error("contact polarity wrong on channel one");
endmodule // wsr_assertions

bind wsr_top wsr_assertions u_wsr_assertions (
  .mclk(mclk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .weight_stable(weight_stable),
  .relay_out(relay_out), .led_out(led_out), .report_req(report_req)
);

/* sim/wsr_partner.sv */
module wsr_partner (
  // Controller side
  input  wire logic       mclk,
  input  wire logic [1:0] relay_out,
  input  wire logic [1:0] led_out,
  // Operator switches and what the field sees
  input  wire logic [1:0] sw,
  output      logic [1:0] logic_in,
  output      logic [1:0] contact,
  output      logic [1:0] lamp
);
  // Pins move just after an edge, never mid-cycle
  always_ff @(posedge mclk) logic_in <= sw;
  assign contact = relay_out;
  assign lamp    = led_out;
endmodule // wsr_partner

/* sim/wsr_top_bench.sv */
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %0h want %0h", $time, g, e); end end
module wsr_top_bench
  import wsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short tick keeps tenth-second counts cheap to simulate
  localparam int TK = 20;
  logic                     mclk = 1'b0;
  logic                     nrst = 1'b0;
  logic [3:0]               avs_address = 4'h0;
  logic                     avs_read = 1'b0;
  logic                     avs_write = 1'b0;
  logic [31:0]              avs_writedata = 32'h0;
  logic signed [WSR_WW-1:0] net_weight = '0;
  logic signed [WSR_WW-1:0] gross_weight = '0;
  logic signed [WSR_WW-1:0] peak_weight = '0;
  logic                     weight_stable = 1'b1;
  logic [1:0]               sw = 2'h0;
  wire  [1:0]               logic_in, relay_out, led_out;
  wire  [31:0]              avs_readdata;
  wire                      avs_waitrequest, report_req;
  int                       mismatches = 0;
  int                       checked = 0;
  int                       cyc = 0;

  always #12.5 mclk = ~mclk;

  wsr_top #(.TICK_CYCLES(TK)) u_wsr_top (
    .mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .net_weight(net_weight),
    .gross_weight(gross_weight), .peak_weight(peak_weight),
    .weight_stable(weight_stable), .logic_in(logic_in),
    .relay_out(relay_out), .led_out(led_out), .report_req(report_req));
  wsr_partner u_wsr_partner (.mclk(mclk), .relay_out(relay_out),
    .led_out(led_out), .sw(sw), .logic_in(logic_in), .contact(),
    .lamp());

  ////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      close_out;
    end
  end

  task automatic cy(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic setw(input logic [1:0] s, input int v, input int o);
    @(posedge mclk);
    net_weight <= (s == 2'h0) ? 24'(v) : 24'(o);
    gross_weight <= (s == 2'h1) ? 24'(v) : 24'(o);
    peak_weight <= (s == 2'h2) ? 24'(v) : 24'(o);
  endtask

  // Cycles until a relay reaches a level, capped
  task automatic wt(input int b, input logic v, output int n);
    n = 0;
    while (relay_out[b] !== v && n < 300) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // Input 2 pulse; counts accepted report requests
  task automatic press(output int k);
    k = 0;
    @(posedge mclk);
    sw[1] <= 1'b1;
    repeat (12) begin
      @(posedge mclk);
      if (report_req !== 1'b0) k++;
    end
    sw[1] <= 1'b0;
    cy(4);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    for (int c = 0; c < 2; c++) begin
      bus(1'b0, {c[0], 3'h1}, 32'h0, d);
      `CHK(d[4:0], 5'h01)
      bus(1'b0, {c[0], 3'h2}, 32'h0, d);
      `CHK(d[9:0], 10'h002)
      bus(1'b0, {c[0], 3'h3}, 32'h0, d);
      `CHK(d[9:0], 10'h000)
      bus(1'b0, {c[0], 3'h4}, 32'h0, d);
      `CHK(d[9:0], 10'h000)
    end
    wr(4'hD, 32'h5A);
    bus(1'b0, 4'hD, 32'h0, d);
    `CHK(d, 32'h0)
    wr(4'h2, 32'h3E8);
    bus(1'b0, 4'h2, 32'h0, d);
    `CHK(d[9:0], 10'h3E7)
    wr(4'h2, 32'h2);
  endtask

  task automatic t_delay;
    int n;
    int m;
    wr(4'h0, 32'd100);
    wr(4'h8, 32'd100);
    wr(4'hB, 32'd3);
    setw(2'h1, 50, 0);
    cy(6);
    `CHK(relay_out, 2'b00)
    setw(2'h1, 200, 0);
    wt(0, 1'b1, n);
    `CHK(n <= 3, 1'b1)
    wt(1, 1'b1, m);
    `CHK((n + m) >= 38 && (n + m) <= 64, 1'b1)
    setw(2'h1, 99, 0);
    cy(6);
    `CHK(relay_out[0], 1'b1)
    `CHK(relay_out[1], 1'b1)
    setw(2'h1, 97, 0);
    wt(0, 1'b0, n);
    `CHK(n <= 4, 1'b1)
    `CHK(relay_out[1], 1'b0)
  endtask

  task automatic t_maxon;
    int n;
    wr(4'hB, 32'd0);
    wr(4'hC, 32'd5);
    wr(4'h4, 32'd5);
    setw(2'h1, 0, 0);
    cy(6);
    setw(2'h1, 200, 0);
    wt(1, 1'b1, n);
    `CHK(n <= 3, 1'b1)
    wt(1, 1'b0, n);
    `CHK(n >= 76 && n <= 104, 1'b1)
    cy(60);
    `CHK(relay_out, 2'b00)
    setw(2'h1, 0, 0);
    cy(4);
    setw(2'h1, 200, 0);
    wt(1, 1'b1, n);
    `CHK(n <= 4, 1'b1)
    wr(4'hC, 32'd0);
    wr(4'h4, 32'd0);
  endtask

  task automatic t_src;
    logic [1:0] s;
    logic [1:0] p;
    // Source code 3 falls back to gross
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      p = (s == 2'h3) ? 2'h1 : s;
      wr(4'h1, {30'h0, s});
      setw(p, 0, 200);
      cy(6);
      `CHK(relay_out[0], 1'b0)
      setw(p, 200, 0);
      cy(6);
      `CHK(relay_out[0], 1'b1)
    end
  endtask

  task automatic t_pol;
    wr(4'h1, 32'h05);
    setw(2'h1, 0, 0);
    cy(6);
    `CHK(relay_out[0], 1'b1)
    setw(2'h1, 200, 0);
    cy(6);
    `CHK({relay_out[0], led_out[0]}, 2'b01)
    wr(4'h1, 32'h09);
    setw(2'h1, -200, 0);
    cy(6);
    `CHK(relay_out[0], 1'b1)
    setw(2'h1, 200, 0);
    cy(6);
    `CHK(relay_out[0], 1'b0)
    wr(4'h1, 32'h11);
    weight_stable <= 1'b0;
    cy(6);
    `CHK(relay_out[0], 1'b0)
    weight_stable <= 1'b1;
    cy(6);
    `CHK(relay_out[0], 1'b1)
    wr(4'h1, 32'h01);
  endtask

  task automatic t_otm;
    for (int i = 0; i < 4; i++) begin
      wr(4'h5, {28'h0, i[1:0], 2'b10});
      cy(4);
      `CHK(relay_out, i[1:0])
      `CHK(led_out, i[1:0])
    end
    wr(4'h5, 32'h0);
  endtask

  task automatic t_rep;
    int k;
    logic [31:0] d;
    setw(2'h1, 100, 0);
    press(k);
    `CHK(k, 0)
    wr(4'h6, 32'h1);
    press(k);
    `CHK(k, 1)
    setw(2'h1, 110, 0);
    press(k);
    `CHK(k, 0)
    setw(2'h1, 120, 0);
    press(k);
    `CHK(k, 1)
    setw(2'h1, 200, 0);
    weight_stable <= 1'b0;
    press(k);
    `CHK(k, 0)
    weight_stable <= 1'b1;
    wr(4'h5, 32'h1);
    press(k);
    `CHK(k, 0)
    sw <= 2'b01;
    cy(6);
    bus(1'b0, 4'h7, 32'h0, d);
    `CHK(d[3:2], 2'b10)
    sw <= 2'b00;
    wr(4'h5, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    cy(20);
    nrst <= 1'b1;
    cy(4);
    t_regs;
    t_delay;
    t_maxon;
    t_src;
    t_pol;
    t_otm;
    t_rep;
    close_out;
  end
endmodule // wsr_top_bench
